// File: tip_pkg.sv
// shared constants and state types for the triple interval timer
package tip_pkg;

    localparam int NUM_CTR = 3;

    // data port and control byte offsets
    localparam logic [1:0] OFS_CTR0 = 2'h0;
    localparam logic [1:0] OFS_CTR1 = 2'h1;
    localparam logic [1:0] OFS_CTR2 = 2'h2;
    localparam logic [1:0] OFS_CTRL = 2'h3;

    // control byte field positions
    localparam int CW_SEL_HI  = 7;
    localparam int CW_SEL_LO  = 6;
    localparam int CW_SEQ_HI  = 5;
    localparam int CW_SEQ_LO  = 4;
    localparam int CW_MODE_HI = 3;
    localparam int CW_MODE_LO = 1;
    localparam int CW_BCD     = 0;

    localparam logic [1:0] SEL_ILLEGAL = 2'h3;

    // access sequence codes
    localparam logic [1:0] SEQ_LATCH = 2'h0;
    localparam logic [1:0] SEQ_LO    = 2'h1;
    localparam logic [1:0] SEQ_HI    = 2'h2;
    localparam logic [1:0] SEQ_LOHI  = 2'h3;

    // operating modes
    localparam logic [2:0] MODE_0 = 3'h0;
    localparam logic [2:0] MODE_1 = 3'h1;
    localparam logic [2:0] MODE_2 = 3'h2;
    localparam logic [2:0] MODE_3 = 3'h3;
    localparam logic [2:0] MODE_4 = 3'h4;
    localparam logic [2:0] MODE_5 = 3'h5;

    // reset values
    localparam logic [2:0]  RST_MODE  = MODE_0;
    localparam logic [1:0]  RST_SEQ   = SEQ_LOHI;
    localparam logic        RST_BCD   = 1'b0;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic        RST_OUT   = 1'b0;
    localparam logic [7:0]  RD_NONE   = 8'h00;

    // pacer source derived from the core clock
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PACER_PERIOD_NS = 500;
    localparam int PACER_DIV_W     = 6;
    localparam logic [PACER_DIV_W-1:0] PACER_DIV_LAST =
        PACER_DIV_W'(PACER_PERIOD_NS / CLK_PERIOD_NS - 1);

    typedef struct packed {
        logic [2:0]  mode;
        logic [1:0]  seq;
        logic        bcd;
        logic [15:0] cr;
        logic [15:0] ce;
        logic [15:0] ol;
        logic [7:0]  lo_hold;
        logic        latched;
        logic        wr_hi;
        logic        rd_hi;
        logic        loaded;
        logic        load_pend;
        logic        trig;
        logic        run;
        logic        out;
        logic        gate_q;
    } tip_ctr_t;

    localparam tip_ctr_t CTR_RST = '{
        mode: RST_MODE, seq: RST_SEQ, bcd: RST_BCD,
        cr: RST_COUNT, ce: RST_COUNT, ol: RST_COUNT,
        out: RST_OUT, default: '0};

    typedef struct packed {
        tip_ctr_t [NUM_CTR-1:0]   ctr;
        logic [PACER_DIV_W-1:0]   div;
        logic                     clk0_q;
        logic                     out1_q;
        logic [7:0]               rd_data;
        logic                     rd_valid;
    } tip_state_t;

endpackage : tip_pkg

// File: tip_sync2.sv
// two flip-flop synchroniser for the counter 0 connector pins
module tip_sync2
    import tip_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [1:0] d,
    output logic      [1:0] q
);

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } tip_sync_t;

    tip_sync_t sync_reg;
    tip_sync_t sync_next;

    always_comb begin
        sync_next    = sync_reg;
        sync_next.s1 = d;
        sync_next.s2 = sync_reg.s1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    // only the second stage leaves this module
    assign q = sync_reg.s2;

endmodule : tip_sync2

// File: tip_timer.sv
// three 16-bit interval counters with byte port access and pacer chain
// Functional notes
// - three independent 16-bit counters
// - counter clocks from DC up to 5 MHz
// - each counter set to one of six modes
// - counters 1 and 2 chained as pacer
// - 2 MHz source, fastest /4, slowest /65536/65536
// - counter 0 clock, gate, output on connector
// - offsets 0-2 counter data, 3 control
// - bits 7:6 select counter, 11 illegal
// - bits 5:4 latch, low, high, low-then-high
// - bits 3:1 pick mode, x10/x11 ignore top
// - bit 0 chooses binary or BCD
// - binary spans 0-65535, BCD 0-9999
// - six modes in customary order
module tip_timer
    import tip_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [1:0] io_addr,
    input  wire logic [7:0] io_wr_data,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    output logic      [7:0] io_rd_data,
    output logic            io_rd_valid,
    input  wire logic       ctr0_clk_pin,
    input  wire logic       ctr0_gate_pin,
    output logic            ctr0_out_pin,
    input  wire logic       pacer_gate,
    output logic            pacer_out
);

    tip_state_t st_reg;
    tip_state_t st_next;

    logic [1:0]         pin_sync;
    logic [NUM_CTR-1:0] tick;
    logic [NUM_CTR-1:0] gate;

    // pins are sampled well above 5 MHz, so edges are never missed
    tip_sync2 u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({ctr0_gate_pin, ctr0_clk_pin}),
        .q        (pin_sync)
    );

    // counters step on the falling edge of their clock
    assign tick[0] = st_reg.clk0_q & ~pin_sync[0];
    assign tick[1] = (st_reg.div == PACER_DIV_LAST);
    assign tick[2] = st_reg.out1_q & ~st_reg.ctr[1].out;
    assign gate[0] = pin_sync[1];
    assign gate[1] = pacer_gate;
    assign gate[2] = pacer_gate;

    // one step down in binary or four-digit decimal, zero wraps to top
    function automatic logic [15:0] tip_dec(
        input logic [15:0] v,
        input logic        bcd
    );
        logic [15:0] r;
        logic        borrow;
        r      = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (borrow) begin
                    if (v[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9;
                    end else begin
                        r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                        borrow      = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : tip_dec

    // top mode bit is a don't-care for the two rate modes
    function automatic logic [2:0] tip_mode(
        input logic [2:0] m
    );
        logic [2:0] r;
        r = m;
        if (m[1]) begin
            r = {1'b0, m[1:0]};
        end
        return r;
    endfunction : tip_mode

    // byte presented on a read of the given counter
    function automatic logic [7:0] tip_rd_byte(
        input tip_ctr_t c
    );
        logic [7:0] r;
        r = c.ol[7:0];
        case (c.seq)
            SEQ_HI: begin
                r = c.ol[15:8];
            end
            SEQ_LOHI: begin
                r = c.rd_hi ? c.ol[15:8] : c.ol[7:0];
            end
            default: begin
                r = c.ol[7:0];
            end
        endcase
        return r;
    endfunction : tip_rd_byte

    always_comb begin
        tip_ctr_t    c;
        logic        g;
        logic        gr;
        logic [1:0]  sel;
        c   = '0;
        g   = 1'b0;
        gr  = 1'b0;
        sel = io_wr_data[CW_SEL_HI:CW_SEL_LO];

        st_next          = st_reg;
        st_next.rd_valid = 1'b0;
        st_next.clk0_q   = pin_sync[0];
        st_next.out1_q   = st_reg.ctr[1].out;
        if (st_reg.div == PACER_DIV_LAST) begin
            st_next.div = '0;
        end else begin
            st_next.div = st_reg.div + PACER_DIV_W'(1);
        end

        if (io_rd && (io_addr == OFS_CTRL)) begin
            st_next.rd_data  = RD_NONE;
            st_next.rd_valid = 1'b1;
        end

        // each counter runs from its own state, tick and gate; counter 2's tick comes from counter 1's output
        for (int i = 0; i < NUM_CTR; i++) begin
            c  = st_reg.ctr[i];
            g  = gate[i];
            gr = g & ~c.gate_q;
            c.gate_q = g;

            if (gr && c.loaded) begin
                c.trig = 1'b1;
            end
            // gate low holds rate outputs high at once
            if (!g && ((c.mode == MODE_2) || (c.mode == MODE_3))) begin
                c.out = 1'b1;
            end

            if (tick[i]) begin
                case (c.mode)
                    MODE_0, MODE_4: begin
                        if (c.mode == MODE_4) begin
                            c.out = 1'b1;
                        end
                        if (c.load_pend) begin
                            c.ce        = c.cr;
                            c.load_pend = 1'b0;
                            c.run       = 1'b1;
                        end else if (c.run && g) begin
                            c.ce = tip_dec(c.ce, c.bcd);
                            if (c.ce == RST_COUNT) begin
                                // one event per load, count then holds
                                c.run = 1'b0;
                                c.out = (c.mode == MODE_0);
                            end
                        end
                    end
                    MODE_1, MODE_5: begin
                        if (c.mode == MODE_5) begin
                            c.out = 1'b1;
                        end
                        if (c.trig) begin
                            c.ce   = c.cr;
                            c.trig = 1'b0;
                            c.run  = 1'b1;
                            c.out  = (c.mode == MODE_5);
                        end else if (c.run) begin
                            c.ce = tip_dec(c.ce, c.bcd);
                            if (c.ce == RST_COUNT) begin
                                c.run = 1'b0;
                                c.out = (c.mode == MODE_1);
                            end
                        end
                    end
                    MODE_2: begin
                        if (g) begin
                            if (c.trig || c.load_pend) begin
                                c.ce        = c.cr;
                                c.out       = 1'b1;
                                c.run       = 1'b1;
                                c.trig      = 1'b0;
                                c.load_pend = 1'b0;
                            end else if (c.run) begin
                                if (c.ce == 16'h0001) begin
                                    c.ce  = c.cr;
                                    c.out = 1'b1;
                                end else begin
                                    c.ce = tip_dec(c.ce, c.bcd);
                                    if (c.ce == 16'h0001) begin
                                        c.out = 1'b0;
                                    end
                                end
                            end
                        end
                    end
                    MODE_3: begin
                        if (g) begin
                            if (c.trig || c.load_pend) begin
                                c.ce        = c.cr;
                                c.out       = 1'b1;
                                c.run       = 1'b1;
                                c.trig      = 1'b0;
                                c.load_pend = 1'b0;
                            end else if (c.run) begin
                                if ((c.ce == 16'h0001) || (c.ce == 16'h0002)) begin
                                    // odd counts give the low half one step less
                                    if (c.out && c.cr[0]) begin
                                        c.ce = {c.cr[15:1], 1'b0};
                                    end else begin
                                        c.ce = c.cr;
                                    end
                                    c.out = ~c.out;
                                end else begin
                                    c.ce = tip_dec(tip_dec(c.ce, c.bcd), c.bcd);
                                end
                            end
                        end
                    end
                    default: begin
                        c.run = 1'b0;
                    end
                endcase
            end

            if (!c.latched) begin
                c.ol = c.ce;
            end

            if (io_rd && (io_addr == 2'(i))) begin
                st_next.rd_data  = tip_rd_byte(c);
                st_next.rd_valid = 1'b1;
                if (c.seq == SEQ_LOHI) begin
                    if (c.rd_hi) begin
                        c.latched = 1'b0;
                    end
                    c.rd_hi = ~c.rd_hi;
                end else begin
                    c.latched = 1'b0;
                end
            end

            if (io_wr && (io_addr == 2'(i))) begin
                // count takes effect only once fully written
                case (c.seq)
                    SEQ_LO: begin
                        c.cr        = {8'h00, io_wr_data};
                        c.loaded    = 1'b1;
                        c.load_pend = 1'b1;
                    end
                    SEQ_HI: begin
                        c.cr        = {io_wr_data, 8'h00};
                        c.loaded    = 1'b1;
                        c.load_pend = 1'b1;
                    end
                    default: begin
                        if (!c.wr_hi) begin
                            c.lo_hold = io_wr_data;
                        end else begin
                            c.cr        = {io_wr_data, c.lo_hold};
                            c.loaded    = 1'b1;
                            c.load_pend = 1'b1;
                        end
                        c.wr_hi = ~c.wr_hi;
                    end
                endcase
                // running rate modes pick the new count up at the next reload
                if (c.run && ((c.mode == MODE_2) || (c.mode == MODE_3))) begin
                    c.load_pend = 1'b0;
                end
                if (c.mode == MODE_0) begin
                    c.out = 1'b0;
                end
            end

            // illegal select code is dropped without side effects
            if (io_wr && (io_addr == OFS_CTRL) && (sel == 2'(i))) begin
                if (io_wr_data[CW_SEQ_HI:CW_SEQ_LO] == SEQ_LATCH) begin
                    if (!c.latched) begin
                        c.ol      = c.ce;
                        c.latched = 1'b1;
                    end
                end else begin
                    c.mode      = tip_mode(io_wr_data[CW_MODE_HI:CW_MODE_LO]);
                    c.seq       = io_wr_data[CW_SEQ_HI:CW_SEQ_LO];
                    c.bcd       = io_wr_data[CW_BCD];
                    c.wr_hi     = 1'b0;
                    c.rd_hi     = 1'b0;
                    c.latched   = 1'b0;
                    c.loaded    = 1'b0;
                    c.load_pend = 1'b0;
                    c.trig      = 1'b0;
                    c.run       = 1'b0;
                    c.out       = (c.mode != MODE_0);
                end
            end

            st_next.ctr[i] = c;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg <= '{ctr: {NUM_CTR{CTR_RST}}, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign io_rd_data   = st_reg.rd_data;
    assign io_rd_valid  = st_reg.rd_valid;
    assign ctr0_out_pin = st_reg.ctr[0].out;
    assign pacer_out    = st_reg.ctr[2].out;

endmodule : tip_timer

// File: tip_timer_assertions.sv
// port-level assertion checker for the triple interval timer
module tip_timer_assertions
    import tip_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [1:0] io_addr,
    input wire logic [7:0] io_wr_data,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_rd_data,
    input wire logic       io_rd_valid,
    input wire logic       ctr0_clk_pin,
    input wire logic       ctr0_gate_pin,
    input wire logic       ctr0_out_pin,
    input wire logic       pacer_gate,
    input wire logic       pacer_out
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // pins quiet long enough that no synchronised edge is still in flight
    logic [1:0] pins_reg;
    logic [2:0] quiet_reg;
    always_ff @(posedge core_clk) begin
        pins_reg <= {ctr0_clk_pin, ctr0_gate_pin};
        if (rst || pins_reg != {ctr0_clk_pin, ctr0_gate_pin}) begin
            quiet_reg <= 3'h0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end

    a_rd_answer: assert property (io_rd |=> io_rd_valid)
        else $error("read not answered one cycle later");
    a_no_spurious: assert property (!io_rd |=> !io_rd_valid)
        else $error("read valid without a read");
    a_rd_hold: assert property (!io_rd |=> $stable(io_rd_data))
        else $error("read data moved without a read");
    a_ctrl_reads_zero: assert property (
        io_rd && io_addr == OFS_CTRL |=> io_rd_data == RD_NONE)
        else $error("control offset read not zero");
    // a mode-setting control byte sets the output low for mode 0, high for any other mode
    a_ctl0_level: assert property (
        io_wr && io_addr == OFS_CTRL && io_wr_data[7:6] == 2'h0
        && io_wr_data[5:4] != SEQ_LATCH
        |=> ctr0_out_pin == ($past(io_wr_data[3:1]) != MODE_0))
        else $error("counter 0 output wrong after control byte");
    a_ctl2_level: assert property (
        io_wr && io_addr == OFS_CTRL && io_wr_data[7:6] == 2'h2
        && io_wr_data[5:4] != SEQ_LATCH
        |=> pacer_out == ($past(io_wr_data[3:1]) != MODE_0))
        else $error("pacer output wrong after control byte");
    a_illegal_ignored: assert property (
        io_wr && io_addr == OFS_CTRL && io_wr_data[7:6] == SEL_ILLEGAL
        && quiet_reg == 3'h7 |=> $stable(ctr0_out_pin))
        else $error("illegal select changed counter 0");
    a_reset_idle: assert property (
        $fell(rst) |-> !io_rd_valid && !ctr0_out_pin && !pacer_out
        && io_rd_data == RD_NONE)
        else $error("outputs not idle after reset");
endmodule : tip_timer_assertions

bind tip_timer tip_timer_assertions i_chk (
    .core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wr_data(io_wr_data),
    .io_wr(io_wr), .io_rd(io_rd), .io_rd_data(io_rd_data), .io_rd_valid(io_rd_valid),
    .ctr0_clk_pin(ctr0_clk_pin), .ctr0_gate_pin(ctr0_gate_pin),
    .ctr0_out_pin(ctr0_out_pin), .pacer_gate(pacer_gate), .pacer_out(pacer_out)
);

// File: tip_host_model.sv
// host processor model driving the timer byte port
module tip_host_model
    import tip_pkg::*;
(
    input  wire logic       core_clk,
    output logic      [1:0] io_addr,
    output logic      [7:0] io_wr_data,
    output logic            io_wr,
    output logic            io_rd,
    input  wire logic [7:0] io_rd_data,
    input  wire logic       io_rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        io_addr = OFS_CTRL;
        io_wr_data = 8'hA5;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end

    // one byte write; control byte goes first, select 11 only on purpose
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_wr_data = d;
        io_wr = 1'b1;
        @(negedge core_clk);
        io_wr = 1'b0;
        // released bus shows no stale byte
        io_wr_data = ~d;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic v);
        @(negedge core_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge core_clk);
        // answer stands only in the cycle after the strobe
        d = io_rd_data;
        v = io_rd_valid;
        io_rd = 1'b0;
    endtask : rd
endmodule : tip_host_model

// File: tb_top.sv
// self-checking bench for the triple interval timer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tip_pkg::*;

    logic       core_clk;
    logic       rst;
    logic [1:0] io_addr;
    logic [7:0] io_wr_data;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_rd_data;
    logic       io_rd_valid;
    logic       ctr0_clk_pin;
    logic       ctr0_gate_pin;
    logic       ctr0_out_pin;
    logic       pacer_gate;
    logic       pacer_out;
    logic [7:0] rd_byte;
    logic       rd_ok;
    int         fail_count;
    int         cmp_count;

    tip_timer i_dut (
        .core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wr_data(io_wr_data),
        .io_wr(io_wr), .io_rd(io_rd), .io_rd_data(io_rd_data), .io_rd_valid(io_rd_valid),
        .ctr0_clk_pin(ctr0_clk_pin), .ctr0_gate_pin(ctr0_gate_pin),
        .ctr0_out_pin(ctr0_out_pin), .pacer_gate(pacer_gate), .pacer_out(pacer_out)
    );

    tip_host_model i_host (
        .core_clk(core_clk), .io_addr(io_addr), .io_wr_data(io_wr_data),
        .io_wr(io_wr), .io_rd(io_rd), .io_rd_data(io_rd_data), .io_rd_valid(io_rd_valid)
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        i_host.rd(a, rd_byte, rd_ok);
        chk("read valid", 16'h0001, {15'h0000, rd_ok});
        chk("read byte", {8'h00, exp}, {8'h00, rd_byte});
    endtask : rd_chk

    // 5 MHz connector clock, the fastest a counter accepts
    task automatic tick0(input int n);
        repeat (n) begin
            @(negedge core_clk);
            ctr0_clk_pin = 1'b0;
            repeat (10) @(negedge core_clk);
            ctr0_clk_pin = 1'b1;
            repeat (9) @(negedge core_clk);
        end
    endtask : tick0

    // negedges until the next pacer fall, bounded
    task automatic fall_gap(output int n);
        n = 0;
        while (pacer_out !== 1'b1 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
        while (pacer_out !== 1'b0 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
    endtask : fall_gap

    task automatic t_reset;
        chk("read valid idle", 16'h0000, {15'h0000, io_rd_valid});
        chk("counter 0 out", 16'h0000, {15'h0000, ctr0_out_pin});
        chk("pacer out", 16'h0000, {15'h0000, pacer_out});
        rd_chk(OFS_CTRL, RD_NONE);
    endtask : t_reset

    task automatic t_mode0;
        i_host.wr(OFS_CTRL, 8'h30);
        i_host.wr(OFS_CTR0, 8'h05);
        i_host.wr(OFS_CTR0, 8'h00);
        tick0(5);
        chk("mode 0 counting", 16'h0000, {15'h0000, ctr0_out_pin});
        tick0(1);
        chk("mode 0 terminal", 16'h0001, {15'h0000, ctr0_out_pin});
        i_host.wr(OFS_CTRL, 8'hF0);
        chk("illegal select", 16'h0001, {15'h0000, ctr0_out_pin});
    endtask : t_mode0

    task automatic t_latch;
        i_host.wr(OFS_CTRL, 8'h34);
        i_host.wr(OFS_CTR0, 8'h34);
        i_host.wr(OFS_CTR0, 8'h12);
        tick0(3);
        i_host.wr(OFS_CTRL, 8'h00);
        tick0(2);
        rd_chk(OFS_CTR0, 8'h32);
        rd_chk(OFS_CTR0, 8'h12);
        i_host.wr(OFS_CTRL, 8'h00);
        rd_chk(OFS_CTR0, 8'h30);
        rd_chk(OFS_CTR0, 8'h12);
    endtask : t_latch

    task automatic t_bcd;
        i_host.wr(OFS_CTRL, 8'h11);
        i_host.wr(OFS_CTR0, 8'h10);
        tick0(2);
        i_host.wr(OFS_CTRL, 8'h00);
        rd_chk(OFS_CTR0, 8'h09);
    endtask : t_bcd

    // codes 6 and 7 fold onto modes 2 and 3
    task automatic t_modes;
        for (int m = 0; m < 8; m++) begin
            i_host.wr(OFS_CTRL, {4'h3, 3'(m), 1'b0});
            chk("out after control", {15'h0000, m != 0}, {15'h0000, ctr0_out_pin});
        end
    endtask : t_modes

    // gate pin rise arms the one-shot, low for three counter clocks
    task automatic t_oneshot;
        i_host.wr(OFS_CTRL, 8'h12);
        chk("one-shot idle", 16'h0001, {15'h0000, ctr0_out_pin});
        i_host.wr(OFS_CTR0, 8'h03);
        @(negedge core_clk);
        ctr0_gate_pin = 1'b0;
        repeat (4) @(negedge core_clk);
        ctr0_gate_pin = 1'b1;
        repeat (4) @(negedge core_clk);
        tick0(1);
        chk("one-shot started", 16'h0000, {15'h0000, ctr0_out_pin});
        tick0(2);
        chk("one-shot width", 16'h0000, {15'h0000, ctr0_out_pin});
        tick0(1);
        chk("one-shot end", 16'h0001, {15'h0000, ctr0_out_pin});
    endtask : t_oneshot

    task automatic t_pacer;
        int n;
        i_host.wr(OFS_CTRL, 8'h74);
        i_host.wr(OFS_CTR1, 8'h02);
        i_host.wr(OFS_CTR1, 8'h00);
        i_host.wr(OFS_CTRL, 8'hB4);
        i_host.wr(OFS_CTR2, 8'h02);
        i_host.wr(OFS_CTR2, 8'h00);
        fall_gap(n);
        fall_gap(n);
        chk("pacer period", 16'h00C8, 16'(n));
        pacer_gate = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("pacer gated", 16'h0001, {15'h0000, pacer_out});
    endtask : t_pacer

    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        fail_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        ctr0_clk_pin = 1'b1;
        ctr0_gate_pin = 1'b1;
        pacer_gate = 1'b1;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_mode0();
        t_latch();
        t_bcd();
        t_modes();
        t_oneshot();
        t_pacer();
        end_sim();
    end

    // all scenarios need well under 3000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : tb_top
